/* File: include/bdma_pkg.sv */
package bdma_pkg;

  // ----------------------------------------
  // address space
  // ----------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          MEM_BYTES     = 4096;
  localparam int          BANK_W        = 4;
  localparam int          OFFS_W        = 8;
  localparam int          NUM_BANKS     = 16;
  localparam int          BANK_BYTES    = 256;
  localparam logic [7:0]  ACC_SPLIT     = 8'h60;
  localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;
  localparam logic [3:0]  ACC_HIGH_BANK = 4'hF;
  localparam logic [11:0] GPR_BASE      = 12'h000;
  localparam logic [11:0] SFR_BASE      = 12'hF38;
  localparam logic [11:0] SFR_TOP       = 12'hFFF;
  localparam logic [11:0] PCL_ADDR      = 12'hFF9;
  localparam logic [11:0] BSEL_ADDR     = 12'hFE0;
  localparam logic [3:0]  BSEL_RESET    = 4'h0;

  // ----------------------------------------
  // apb register map
  // ----------------------------------------
  localparam logic [11:0] REG_BSEL      = 12'h000;
  localparam logic [11:0] REG_CFG       = 12'h004;
  localparam logic [11:0] REG_STAT      = 12'h008;

  // ----------------------------------------
  // quarter-cycle phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    BDMA_Q1,
    BDMA_Q2,
    BDMA_Q3,
    BDMA_Q4
  } bdma_q_t;

endpackage

/* File: design/bdma_ram.sv */
`timescale 1ns/10ps
module bdma_ram #(
  parameter int DEPTH = 2048,
  parameter int AW    = 11
) (
  // clock
  input  wire logic          ref_clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [DEPTH];

  // ----------------------------------------
  // storage, never cleared by reset
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

/* File: design/bdma_core.sv */
`timescale 1ns/10ps
// Operation
// - data addresses are twelve bits, 4096 bytes
// - sixteen banks of 256 bytes each
// - unimplemented locations read as zero
// - bank select gives top four bits
// - only low four bank bits stored
// - load bank literal writes bank select
// - unimplemented bank: writes dropped, reads zero
// - status flags updated as if successful
// - full-address move ignores bank select
// - other instructions use bank or access map
// - access map: 00-5F bank0, 60-FF bank15
// - access bit one banked, zero access map
// - access-bank operation completes in one cycle
// - extended set enable exposed, unextended map
// - general registers start at address zero
// - general registers never cleared by reset
// - bank15 offset F9 write hits program counter
// - special registers span F38 to FFF
// - read in Q2, write in Q4
module bdma_core
  import bdma_pkg::*;
#(
  parameter int          GPR_BYTES = 2048,
  parameter int          GPR_AW    = 11
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // instruction side
  input  wire logic        op_valid,
  input  wire logic        op_full_move,
  input  wire logic        op_access_bit,
  input  wire logic [7:0]  op_offset,
  input  wire logic [11:0] op_src_addr,
  input  wire logic [11:0] op_dst_addr,
  input  wire logic        op_write,
  input  wire logic [7:0]  op_wdata,
  input  wire logic        load_bank_literal,
  input  wire logic [7:0]  bank_literal,
  input  wire logic        extended_set_enable,
  // special register side
  input  wire logic [7:0]  sfr_rdata,
  // results
  output logic      [7:0]  op_rdata,
  output logic             op_done,
  output logic             sfr_we,
  output logic      [11:0] sfr_addr,
  output logic      [7:0]  sfr_wdata,
  output logic             program_counter_low_we,
  output logic      [3:0]  bank_select_register,
  output bdma_q_t          q_phase
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_gpr(input logic [11:0] a);
    is_gpr = (a >= GPR_BASE) && (a < GPR_BASE + 12'(GPR_BYTES));
  endfunction

  function automatic logic is_sfr(input logic [11:0] a);
    // special range top of bank 15
    is_sfr = (a >= SFR_BASE) && (a <= SFR_TOP);
  endfunction

  // ----------------------------------------
  // quarter-cycle sequencer
  // ----------------------------------------
  bdma_q_t next_q;
  assign next_q = bdma_q_t'(2'(q_phase + 2'd1));

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q_phase <= BDMA_Q1;
    end else begin
      q_phase <= next_q;
    end
  end

  // ----------------------------------------
  // effective address
  // ----------------------------------------
  // twelve-bit banked address
  logic [11:0] banked_addr;
  logic [11:0] access_addr;
  logic [11:0] rd_addr;
  logic [11:0] wr_addr;
  logic [3:0]  access_bank;

  assign access_bank = (op_offset < ACC_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK;
  assign banked_addr = {bank_select_register, op_offset};
  assign access_addr = {access_bank, op_offset};
  assign rd_addr = op_full_move  ? op_src_addr :
                   op_access_bit ? banked_addr : access_addr;
  assign wr_addr = op_full_move  ? op_dst_addr :
                   op_access_bit ? banked_addr : access_addr;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic wr_q4;
  logic gpr_we;
  logic sfr_hit_we;
  logic bsel_hit_we;
  logic pcl_hit_we;
  logic apb_acc;
  logic apb_wr;

  assign apb_acc     = psel && penable;
  assign apb_wr      = apb_acc && pwrite && (paddr == REG_BSEL);
  assign wr_q4       = op_valid && op_write && (q_phase == BDMA_Q4);
  assign gpr_we      = wr_q4 && is_gpr(wr_addr);
  assign sfr_hit_we  = wr_q4 && is_sfr(wr_addr);
  assign bsel_hit_we = sfr_hit_we && (wr_addr == BSEL_ADDR);
  // write to offset F9 in bank 15
  assign pcl_hit_we  = sfr_hit_we && (wr_addr == PCL_ADDR);

  // ----------------------------------------
  // bank select register
  // ----------------------------------------
  logic [3:0] next_bsel;

  assign next_bsel = load_bank_literal ? bank_literal[3:0] :
                     bsel_hit_we       ? op_wdata[3:0]     :
                     apb_wr            ? pwdata[3:0]       : bank_select_register;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bank_select_register <= BSEL_RESET;
    end else begin
      bank_select_register <= next_bsel;
    end
  end

  // ----------------------------------------
  // general register memory
  // ----------------------------------------
  logic [7:0] gpr_rdata;

  bdma_ram #(
    .DEPTH (GPR_BYTES),
    .AW    (GPR_AW)
  ) u_ram (
    .ref_clk (ref_clk),
    .we      (gpr_we),
    .waddr   (wr_addr[GPR_AW-1:0]),
    .wdata   (op_wdata),
    .raddr   (rd_addr[GPR_AW-1:0]),
    .rdata   (gpr_rdata)
  );

  // ----------------------------------------
  // operand read
  // ----------------------------------------
  logic       rd_gpr;
  logic       rd_sfr;
  logic       rd_bsel;
  logic [7:0] next_rdata;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_gpr  <= 1'b0;
      rd_sfr  <= 1'b0;
      rd_bsel <= 1'b0;
    end else begin
      rd_gpr  <= is_gpr(rd_addr);
      rd_sfr  <= is_sfr(rd_addr);
      rd_bsel <= (rd_addr == BSEL_ADDR);
    end
  end

  assign next_rdata = rd_bsel ? {4'h0, bank_select_register} :
                      rd_gpr  ? gpr_rdata :
                      rd_sfr  ? sfr_rdata : 8'h00;

  // operand captured at end of Q3
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      op_rdata <= 8'h00;
    end else if (op_valid && q_phase == BDMA_Q3) begin
      op_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // completion and special register port
  // ----------------------------------------
  // done flags success even for dropped accesses
  // one instruction cycle, done pulses in the Q1 after Q4
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      op_done                <= 1'b0;
      sfr_we                 <= 1'b0;
      sfr_addr               <= 12'h000;
      sfr_wdata              <= 8'h00;
      program_counter_low_we <= 1'b0;
    end else begin
      op_done                <= op_valid && (q_phase == BDMA_Q4);
      sfr_we                 <= sfr_hit_we && !bsel_hit_we;
      sfr_addr               <= sfr_hit_we ? wr_addr : op_valid ? rd_addr : 12'h000;
      sfr_wdata              <= op_wdata;
      program_counter_low_we <= pcl_hit_we;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic [31:0] next_prdata;
  logic        apb_known;

  assign apb_known   = (paddr == REG_BSEL) || (paddr == REG_CFG) || (paddr == REG_STAT);
  assign next_prdata = (paddr == REG_BSEL) ? {28'h0, bank_select_register} :
                       (paddr == REG_CFG)  ? {31'h0, extended_set_enable}  :
                       (paddr == REG_STAT) ? {28'h0, op_valid, op_done, q_phase} :
                                             32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= next_prdata;
      pslverr <= psel && !penable && !apb_known;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  bank_literal_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    load_bank_literal |=> bank_select_register == $past(bank_literal[3:0]))
    else $error("bank literal not loaded");

  full_move_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    op_full_move |-> rd_addr == op_src_addr && wr_addr == op_dst_addr)
    else $error("full move address wrong");

  access_map_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!op_full_move && !op_access_bit) |->
      rd_addr[11:8] == ((op_offset < ACC_SPLIT) ? ACC_LOW_BANK : ACC_HIGH_BANK))
    else $error("access map bank wrong");

  banked_addr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!op_full_move && op_access_bit) |-> rd_addr == {bank_select_register, op_offset})
    else $error("banked address wrong");

  unimpl_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (op_valid && q_phase == BDMA_Q2 && !is_gpr(rd_addr) && !is_sfr(rd_addr))
      |=> ##1 op_rdata == 8'h00)
    else $error("unimplemented read not zero");

  drop_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    gpr_we |-> wr_q4 && wr_addr < 12'(GPR_BYTES))
    else $error("write outside memory");

  pcl_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_q4 && op_access_bit && !op_full_move && bank_select_register == 4'hF
      && op_offset == 8'hF9) |=> program_counter_low_we)
    else $error("program counter low missed");

  done_timing_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (op_valid && q_phase == BDMA_Q4) |=> op_done ##1 !op_done)
    else $error("done pulse wrong");

  upper_bits_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (pready && paddr == REG_BSEL) |-> prdata[31:4] == 28'h0)
    else $error("bank upper bits not zero");

  sfr_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sfr_hit_we && !bsel_hit_we) |=> sfr_we && sfr_addr == $past(wr_addr))
    else $error("special write address wrong");

  bsel_data_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (bsel_hit_we && !load_bank_literal) |=> bank_select_register == $past(op_wdata[3:0]))
    else $error("bank select data write lost");

endmodule

/* File: bench/bdma_cpu_model.sv */
`timescale 1ns/10ps
module bdma_cpu_model
  import bdma_pkg::*;
(
  // clock and phase
  input  wire logic        ref_clk,
  input  wire bdma_q_t     q_phase,
  // core results
  input  wire logic [11:0] sfr_addr,
  input  wire logic [7:0]  op_rdata,
  input  wire logic        op_done,
  // instruction side
  output logic             op_valid,
  output logic             op_full_move,
  output logic             op_access_bit,
  output logic [7:0]       op_offset,
  output logic [11:0]      op_src_addr,
  output logic [11:0]      op_dst_addr,
  output logic             op_write,
  output logic [7:0]       op_wdata,
  output logic [7:0]       sfr_rdata
);
  // ----------------------------------------
  // special register contents
  // ----------------------------------------
  assign sfr_rdata = sfr_addr[7:0] ^ 8'h5A;

  initial begin
    op_valid      = 1'b0;
    op_full_move  = 1'b0;
    op_access_bit = 1'b0;
    op_offset     = 8'h00;
    op_src_addr   = 12'h000;
    op_dst_addr   = 12'h000;
    op_write      = 1'b0;
    op_wdata      = 8'h00;
  end

  // ----------------------------------------
  // one instruction over Q1..Q4
  // ----------------------------------------
  task automatic run_op(input logic full, acc, input logic [7:0] offs,
                        input logic [11:0] src, input logic wr, input logic [7:0] wd,
                        output logic [7:0] rd, output logic done, output logic ok);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (q_phase !== BDMA_Q4 && n < 8) begin
      n++;
      @(negedge ref_clk);
    end
    ok = (n < 8);
    @(posedge ref_clk);
    op_valid      <= 1'b1;
    op_full_move  <= full;
    op_access_bit <= acc;
    op_offset     <= offs;
    op_src_addr   <= src;
    op_dst_addr   <= src;
    op_write      <= wr;
    op_wdata      <= wd;
    repeat (4) @(posedge ref_clk);
    op_valid      <= 1'b0;
    op_write      <= 1'b0;
    op_offset     <= ~offs;
    op_wdata      <= ~wd;
    @(negedge ref_clk);
    rd   = op_rdata;
    done = op_done;
  endtask
endmodule

/* File: bench/banked_data_memory_addressing_tb.sv */
`timescale 1ns/10ps
module banked_data_memory_addressing_tb;
  import bdma_pkg::*;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, sfr_addr, op_src_addr, op_dst_addr;
  logic [31:0] pwdata, prdata, rd;
  logic op_valid, op_full_move, op_access_bit, op_write, op_done, err;
  logic [7:0] op_offset, op_wdata, op_rdata, sfr_rdata, sfr_wdata, bank_literal;
  logic load_bank_literal, extended_set_enable, sfr_we, program_counter_low_we, pcl_seen;
  logic [3:0] bank_select_register;
  bdma_q_t q_phase;
  int failures, n_checks;

  bdma_core u_dut (.*);
  bdma_cpu_model u_cpu (.ref_clk(ref_clk), .q_phase(q_phase), .sfr_addr(sfr_addr),
    .op_rdata(op_rdata), .op_done(op_done), .op_valid(op_valid),
    .op_full_move(op_full_move), .op_access_bit(op_access_bit), .op_offset(op_offset),
    .op_src_addr(op_src_addr), .op_dst_addr(op_dst_addr), .op_write(op_write),
    .op_wdata(op_wdata), .sfr_rdata(sfr_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (sys_rst) pcl_seen <= 1'b0;
    else if (program_counter_low_we === 1'b1) pcl_seen <= 1'b1;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wd;
    if (n >= 16) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic op(input logic full, acc, input logic [7:0] offs, input logic [11:0] src,
                    input logic wr, input logic [7:0] wd, exp);
    logic [7:0] r;
    logic done, ok;
    u_cpu.run_op(full, acc, offs, src, wr, wd, r, done, ok);
    if (!ok) begin
      failures++;
      wrap_up();
    end
    check({31'h0, done}, 32'h1);
    if (!wr) check({24'h0, r}, {24'h0, exp});
  endtask
  task automatic lit(input logic [7:0] v);
    @(posedge ref_clk);
    load_bank_literal <= 1'b1;
    bank_literal      <= v;
    @(posedge ref_clk);
    load_bank_literal <= 1'b0;
    @(negedge ref_clk);
    check({28'h0, bank_select_register}, {28'h0, v[3:0]});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(1'b0, REG_BSEL, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, REG_BSEL, 32'hFF);
    apb(1'b0, REG_BSEL, 32'h0);
    check(rd, 32'h0000000F);
    apb(1'b0, REG_CFG, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask
  task automatic t_banked();
    lit(8'hA3);
    op(1'b0, 1'b1, 8'h44, 12'h000, 1'b1, 8'h5C, 8'h00);
    op(1'b0, 1'b0, 8'h44, 12'h000, 1'b1, 8'h21, 8'h00);
    op(1'b0, 1'b1, 8'h44, 12'h000, 1'b0, 8'h00, 8'h5C);
    op(1'b0, 1'b0, 8'h44, 12'h000, 1'b0, 8'h00, 8'h21);
    lit(8'h07);
    op(1'b1, 1'b1, 8'h00, 12'h344, 1'b0, 8'h00, 8'h5C);
    op(1'b1, 1'b0, 8'h00, 12'h044, 1'b0, 8'h00, 8'h21);
  endtask
  task automatic t_access();
    op(1'b0, 1'b0, 8'h5F, 12'h000, 1'b1, 8'h3E, 8'h00);
    op(1'b0, 1'b0, 8'h5F, 12'h000, 1'b0, 8'h00, 8'h3E);
    op(1'b0, 1'b0, 8'h60, 12'h000, 1'b0, 8'h00, 8'h3A);
    op(1'b1, 1'b0, 8'h00, 12'hF38, 1'b0, 8'h00, 8'h62);
  endtask
  task automatic t_unimpl();
    op(1'b1, 1'b0, 8'h00, 12'h122, 1'b1, 8'h4B, 8'h00);
    lit(8'h09);
    op(1'b0, 1'b1, 8'h22, 12'h000, 1'b1, 8'h77, 8'h00);
    op(1'b0, 1'b1, 8'h22, 12'h000, 1'b0, 8'h00, 8'h00);
    op(1'b1, 1'b0, 8'h00, 12'h122, 1'b0, 8'h00, 8'h4B);
    op(1'b1, 1'b0, 8'h00, 12'h922, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic t_reset();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check({28'h0, bank_select_register}, 32'h0);
    op(1'b1, 1'b0, 8'h00, 12'h344, 1'b0, 8'h00, 8'h5C);
  endtask
  task automatic t_pcl();
    check({31'h0, pcl_seen}, 32'h0);
    lit(8'h0F);
    op(1'b0, 1'b1, 8'hF9, 12'h000, 1'b1, 8'h10, 8'h00);
    check({11'h0, sfr_we, sfr_addr, sfr_wdata}, {11'h0, 1'b1, PCL_ADDR, 8'h10});
    check({31'h0, program_counter_low_we}, 32'h1);
    @(negedge ref_clk);
    check({31'h0, pcl_seen}, 32'h1);
    op(1'b0, 1'b1, 8'hE0, 12'h000, 1'b1, 8'hAB, 8'h00);
    check({31'h0, sfr_we}, 32'h0);
    check({28'h0, bank_select_register}, 32'h0000000B);
    op(1'b0, 1'b0, 8'hE0, 12'h000, 1'b0, 8'h00, 8'h0B);
    op(1'b1, 1'b0, 8'h00, 12'hF40, 1'b1, 8'h66, 8'h00);
    check({11'h0, sfr_we, sfr_addr, sfr_wdata}, {11'h0, 1'b1, 12'hF40, 8'h66});
  endtask

  initial begin
    {psel, penable, pwrite, load_bank_literal} = 4'h0;
    {paddr, pwdata, bank_literal} = 52'h0;
    extended_set_enable = 1'b1;
    failures = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check({28'h0, bank_select_register}, 32'h0);
    t_regs();
    t_banked();
    t_access();
    t_unimpl();
    t_reset();
    t_pcl();
    wrap_up();
  end
endmodule
